/* hdl/lcd_consts.svh */
// Command codes, status layout, reset values and serial link constants of the host port
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Command opcodes (full byte or leading bits)
`define LCD_OP_DISP_ONOFF   7'h57
`define LCD_OP_SEG_MAP      7'h50
`define LCD_OP_INVERSE      7'h53
`define LCD_OP_ALL_ON       7'h52
`define LCD_OP_START_LINE   2'h1
`define LCD_OP_PAGE         4'hB
`define LCD_OP_COL_HI       4'h1
`define LCD_OP_COL_LO       4'h0
`define LCD_OP_RMW_ENTER    8'hE0
`define LCD_OP_RMW_END      8'hEE
`define LCD_OP_SOFT_RESET   8'hE2
`define LCD_OP_BOOSTER      8'hF8

////////////////////////////////////////////////////////////////////////////////
// Status byte bit positions, low nibble reads zero
`define LCD_ST_BUSY         7
`define LCD_ST_SEG_REV      6
`define LCD_ST_DISP_OFF     5
`define LCD_ST_RESET        4
`define LCD_ST_LOW          4'h0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define LCD_RST_START_LINE  6'h00
`define LCD_RST_PAGE        4'h0
`define LCD_RST_COL         8'h00
`define LCD_RST_BOOSTER     2'h0
`define LCD_RST_BYTE        8'h00

////////////////////////////////////////////////////////////////////////////////
// Serial link: index of the last bit of a byte; input warm-up length
`define LCD_SER_LAST_BIT    3'h7
`define LCD_WARM_DONE       2'h3

`endif

/* hdl/lcd_pkg.sv */
// Types shared by the host port, its input synchroniser and its write buffer
package lcd_pkg;

  // Host-side pins as seen by the device
  typedef struct packed {
    logic       iface_par;   // High: parallel bus, low: serial link
    logic       style_en;    // High: enable strobe, low: separate strobes
    logic       cs_n;
    logic       dc;          // High: display data, low: command/status
    logic       rd;          // Read strobe or enable clock
    logic       wr;          // Write strobe or direction line
    logic [7:0] d;
  } lcd_pins_t;

  // One display RAM write
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] data;
  } lcd_ram_wr_t;

  // Display mode settings
  typedef struct packed {
    logic       disp_on;
    logic       seg_rev;
    logic       inverse;
    logic       all_on;
    logic       power_save;
    logic       rmw;
    logic [1:0] booster;
    logic [5:0] start_line;
  } lcd_mode_t;

  typedef enum logic [0:0] {
    LCD_DEC_IDLE      = 1'b0,
    LCD_DEC_BOOST_ARG = 1'b1
  } lcd_dec_state_t;

endpackage : lcd_pkg

/* hdl/lcd_sync.sv */
// Two-flop synchroniser for every host pin
`timescale 1ns/1ps
module lcd_sync (
  input  wire logic              clk,       // System clock
  input  wire logic              nrst,      // Async reset, active low
  input  wire lcd_pkg::lcd_pins_t pin_async, // Raw pins
  output lcd_pkg::lcd_pins_t      pin_sync   // Pins after two flops
);
  import lcd_pkg::*;

  lcd_pins_t meta;

  genvar i;
  generate
    for (i = 0; i < $bits(lcd_pins_t); i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta[i]     <= 1'b0;
          pin_sync[i] <= 1'b0;
        end else begin
          meta[i]     <= pin_async[i];
          pin_sync[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : lcd_sync

/* hdl/lcd_wbuf.sv */
// Two-entry buffer for display RAM writes, head entry straight from flops
`timescale 1ns/1ps
module lcd_wbuf (
  input  wire logic                clk,       // System clock
  input  wire logic                nrst,      // Async reset, active low
  input  wire logic                in_valid,  // Write offered
  output logic                     in_ready,  // Room for a write
  input  wire lcd_pkg::lcd_ram_wr_t in_data,   // Offered write
  output logic                     out_valid, // Head entry valid
  input  wire logic                out_ready, // Receiver takes head
  output lcd_pkg::lcd_ram_wr_t      out_data   // Head entry
);
  import lcd_pkg::*;

  logic        v1;
  lcd_ram_wr_t e1;
  logic        next_v0;
  logic        next_v1;
  lcd_ram_wr_t next_e0;
  lcd_ram_wr_t next_e1;
  logic        pop;
  logic        push;

  assign in_ready = ~v1;

  always_comb begin
    pop     = out_valid & out_ready;
    push    = in_valid & ~v1;
    next_v0 = out_valid;
    next_v1 = v1;
    next_e0 = out_data;
    next_e1 = e1;
    // Shift forward first so a push in the same cycle can take the head slot freed by the pop
    if (pop) begin
      next_v0 = v1;
      next_e0 = e1;
      next_v1 = 1'b0;
    end
    if (push) begin
      if (!next_v0) begin
        next_v0 = 1'b1;
        next_e0 = in_data;
      end else begin
        next_v1 = 1'b1;
        next_e1 = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      v1        <= 1'b0;
      out_data  <= '0;
      e1        <= '0;
    end else begin
      out_valid <= next_v0;
      v1        <= next_v1;
      out_data  <= next_e0;
      e1        <= next_e1;
    end
  end

endmodule : lcd_wbuf

/* hdl/lcd_host_port.sv */
// Host port and command decoder of a dot-matrix display controller
//
// Summary of operation
// - Interface select high: parallel, low: serial
// - Style select high: enable strobe, low: separate strobes
// - Serial data on bit 7, clock on 6
// - Chip select inactive: bus released, activity ignored
// - Separate scheme: drive bus only while read low
// - Enable scheme: high enable frames each access
// - Separate scheme: capture data at write rising edge
// - Enable scheme: direction high read, low write
// - Data/command high: RAM data, low: command/status
// - Display on/off command
// - Start line command loads six bits
// - Page command loads four bits
// - Column address set by two nibbles
// - Command read returns status, low nibble zero
// - Data write stores RAM, data read returns RAM
// - Segment mapping normal or reversed
// - Pixel polarity normal or inverted
// - All pixels forced on or normal
// - Read-modify-write: writes advance column, reads do not
// - Booster command takes a second ratio byte
// - Power save is display off plus all on
`timescale 1ns/1ps
`include "lcd_consts.svh"
module lcd_host_port (
  input  wire logic                clk,                       // System clock, 10 MHz
  input  wire logic                nrst,                      // Async reset, active low
  input  wire logic                iface_serial_parallel_sel, // High parallel, low serial
  input  wire logic                strobe_style_sel,          // High enable strobe, low separate strobes
  input  wire logic                chip_select_n,             // Chip select, active low
  input  wire logic                data_cmd_sel,              // High data, low command
  input  wire logic                rd_strobe,                 // Read strobe or enable clock
  input  wire logic                wr_strobe,                 // Write strobe or direction
  input  wire logic [7:0]          data_in,                   // Data bus, pin level
  output logic [7:0]               data_out,                  // Data bus, driven value
  output logic                     data_oe,                   // Data bus driven
  output logic                     ram_wr_valid,              // RAM write offered
  input  wire logic                ram_wr_ready,              // RAM takes write
  output lcd_pkg::lcd_ram_wr_t      ram_wr,                    // RAM write address and data
  output logic [3:0]               page_addr,                 // Current page, also RAM read address
  output logic [7:0]               col_addr,                  // Current column, also RAM read address
  input  wire logic [7:0]          ram_rd_data,               // RAM contents at page and column
  output lcd_pkg::lcd_mode_t        mode,                      // Display mode settings
  output logic                     host_busy                  // Write buffer full
);
  import lcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and edge tracking

  lcd_pins_t      pin_raw;
  lcd_pins_t      s;
  lcd_pins_t      p;
  logic [1:0]     warm;
  logic [1:0]     next_warm;

  assign pin_raw = {iface_serial_parallel_sel, strobe_style_sel, chip_select_n,
                    data_cmd_sel, rd_strobe, wr_strobe, data_in};

  lcd_sync u_sync (
    .clk       (clk),
    .nrst      (nrst),
    .pin_async (pin_raw),
    .pin_sync  (s)
  );

  // Edges are ignored until the synchroniser holds real pin levels
  always_comb begin
    next_warm = (warm == `LCD_WARM_DONE) ? warm : warm + 2'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warm <= 2'h0;
      p    <= '0;
    end else begin
      warm <= next_warm;
      p    <= s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access detection

  logic       sel;
  logic       par;
  logic       sep;
  logic       rd_active;
  logic       rd_active_q;
  logic       rd_start;
  logic       rd_end;
  logic       par_wr_ev;
  logic       ser_bit_ev;
  logic       ser_byte_ev;
  logic       byte_ev;
  logic       byte_dc;
  logic [7:0] byte_val;

  always_comb begin
    sel = (warm == `LCD_WARM_DONE) & ~s.cs_n;
    par = s.iface_par;
    sep = ~s.style_en;
    // Separate strobes: drive while read low; enable style: while enable high and direction read
    rd_active = par & sel & (sep ? ~s.rd : (s.rd & s.wr));
    rd_start  = rd_active & ~rd_active_q;
    rd_end    = ~rd_active & rd_active_q;
    // Write taken from the last sample before the closing edge
    par_wr_ev = par & sel & (sep ? (~p.wr & s.wr)
                                 : (p.rd & ~s.rd & ~p.wr));
    ser_bit_ev = ~par & sel & s.d[6] & ~p.d[6];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial shifter

  logic [6:0] ser_sh;
  logic [2:0] ser_cnt;
  logic [6:0] next_ser_sh;
  logic [2:0] next_ser_cnt;

  always_comb begin
    next_ser_sh  = ser_sh;
    next_ser_cnt = ser_cnt;
    ser_byte_ev  = ser_bit_ev & (ser_cnt == `LCD_SER_LAST_BIT);
    if (~sel | par) begin
      next_ser_cnt = 3'h0;
    end else if (ser_bit_ev) begin
      next_ser_sh  = {ser_sh[5:0], s.d[7]};
      next_ser_cnt = ser_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_sh  <= 7'h00;
      ser_cnt <= 3'h0;
    end else begin
      ser_sh  <= next_ser_sh;
      ser_cnt <= next_ser_cnt;
    end
  end

  always_comb begin
    byte_ev  = par_wr_ev | ser_byte_ev;
    byte_dc  = par ? p.dc : s.dc;
    byte_val = par ? p.d : {ser_sh, s.d[7]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Display RAM write buffer

  logic        buf_in_valid;
  logic        buf_in_ready;
  lcd_ram_wr_t buf_in;

  lcd_wbuf u_wbuf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (ram_wr_valid),
    .out_ready (ram_wr_ready),
    .out_data  (ram_wr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command decoder and address counters

  logic           rd_dc_q;
  lcd_dec_state_t dec_state;
  lcd_dec_state_t next_dec_state;
  lcd_mode_t      next_mode;
  logic [3:0]     next_page;
  logic [7:0]     next_col;
  logic           next_busy;

  always_comb begin
    next_dec_state = dec_state;
    next_mode      = mode;
    next_page      = page_addr;
    next_col       = col_addr;
    buf_in_valid   = 1'b0;
    buf_in         = {page_addr, col_addr, byte_val};
    if (byte_ev & byte_dc) begin
      // A write while both entries are full is dropped; the busy flag warns the host
      buf_in_valid = 1'b1;
      if (buf_in_ready) begin
        next_col = col_addr + 8'h01;
      end
    end else if (byte_ev) begin
      unique case (dec_state)
        LCD_DEC_BOOST_ARG: begin
          next_mode.booster = byte_val[1:0];
          next_dec_state    = LCD_DEC_IDLE;
        end
        LCD_DEC_IDLE: begin
          if (byte_val[7:1] == `LCD_OP_DISP_ONOFF) begin
            next_mode.disp_on = byte_val[0];
          end else if (byte_val[7:6] == `LCD_OP_START_LINE) begin
            next_mode.start_line = byte_val[5:0];
          end else if (byte_val[7:4] == `LCD_OP_PAGE) begin
            next_page = byte_val[3:0];
          end else if (byte_val[7:4] == `LCD_OP_COL_HI) begin
            next_col = {byte_val[3:0], col_addr[3:0]};
          end else if (byte_val[7:4] == `LCD_OP_COL_LO) begin
            next_col = {col_addr[7:4], byte_val[3:0]};
          end else if (byte_val[7:1] == `LCD_OP_SEG_MAP) begin
            next_mode.seg_rev = byte_val[0];
          end else if (byte_val[7:1] == `LCD_OP_INVERSE) begin
            next_mode.inverse = byte_val[0];
          end else if (byte_val[7:1] == `LCD_OP_ALL_ON) begin
            next_mode.all_on = byte_val[0];
          end else if (byte_val == `LCD_OP_RMW_ENTER) begin
            next_mode.rmw = 1'b1;
          end else if (byte_val == `LCD_OP_RMW_END) begin
            next_mode.rmw = 1'b0;
          end else if (byte_val == `LCD_OP_BOOSTER) begin
            next_dec_state = LCD_DEC_BOOST_ARG;
          end else if (byte_val == `LCD_OP_SOFT_RESET) begin
            next_mode.start_line = `LCD_RST_START_LINE;
            next_mode.rmw        = 1'b0;
            next_page            = `LCD_RST_PAGE;
            next_col             = `LCD_RST_COL;
          end
        end
      endcase
    end else if (rd_end & rd_dc_q & ~mode.rmw) begin
      next_col = col_addr + 8'h01;
    end
    next_mode.power_save = ~next_mode.disp_on & next_mode.all_on;
    next_busy = ~buf_in_ready;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_state <= LCD_DEC_IDLE;
      mode      <= '{disp_on: 1'b0, seg_rev: 1'b0, inverse: 1'b0, all_on: 1'b0,
                     power_save: 1'b0, rmw: 1'b0, booster: `LCD_RST_BOOSTER,
                     start_line: `LCD_RST_START_LINE};
      page_addr <= `LCD_RST_PAGE;
      col_addr  <= `LCD_RST_COL;
      host_busy <= 1'b0;
    end else begin
      dec_state <= next_dec_state;
      mode      <= next_mode;
      page_addr <= next_page;
      col_addr  <= next_col;
      host_busy <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic       next_rd_dc;
  logic [7:0] next_data_out;
  logic [7:0] status;

  always_comb begin
    status                   = {4'h0, `LCD_ST_LOW};
    status[`LCD_ST_BUSY]     = ~buf_in_ready;
    status[`LCD_ST_SEG_REV]  = mode.seg_rev;
    status[`LCD_ST_DISP_OFF] = ~mode.disp_on;
    status[`LCD_ST_RESET]    = 1'b0;
    next_rd_dc    = rd_dc_q;
    next_data_out = data_out;
    if (rd_start) begin
      next_rd_dc    = s.dc;
      next_data_out = s.dc ? ram_rd_data : status;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_active_q <= 1'b0;
      rd_dc_q     <= 1'b0;
      data_out    <= `LCD_RST_BYTE;
      data_oe     <= 1'b0;
    end else begin
      rd_active_q <= rd_active;
      rd_dc_q     <= next_rd_dc;
      data_out    <= next_data_out;
      data_oe     <= rd_active;
    end
  end

endmodule : lcd_host_port

/* tb/lcd_host_port_chk.sv */
// Assertions on the pins, modes and write buffer of the display host port
`timescale 1ns/1ps
module lcd_host_port_chk (
  input wire logic                 clk,                       // Clock
  input wire logic                 nrst,                      // Reset
  input wire logic                 iface_serial_parallel_sel, // Interface
  input wire logic                 strobe_style_sel,          // Style
  input wire logic                 chip_select_n,             // Select
  input wire logic                 data_cmd_sel,              // Data/command
  input wire logic                 rd_strobe,                 // Read/enable
  input wire logic                 wr_strobe,                 // Write/direction
  input wire logic [7:0]           data_in,                   // Bus level
  input wire logic [7:0]           data_out,                  // Bus value
  input wire logic                 data_oe,                   // Bus driven
  input wire logic                 ram_wr_valid,              // Write offered
  input wire logic                 ram_wr_ready,              // Write taken
  input wire lcd_pkg::lcd_ram_wr_t ram_wr,                    // Write entry
  input wire logic [3:0]           page_addr,                 // Page
  input wire logic [7:0]           col_addr,                  // Column
  input wire logic [7:0]           ram_rd_data,               // RAM data
  input wire lcd_pkg::lcd_mode_t   mode,                      // Modes
  input wire logic                 host_busy                  // Buffer full
);
  import lcd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  AST_SER_NO_DRIVE: assert property (!iface_serial_parallel_sel [*5] |-> !data_oe)
    else $error("bus driven in serial mode");
  AST_CS_OFF: assert property (chip_select_n [*5] |-> !data_oe)
    else $error("bus driven while deselected");
  AST_CS_QUIET: assert property (chip_select_n [*6] |-> $stable(mode) && $stable(col_addr))
    else $error("state changed while deselected");
  AST_SEP_RD: assert property ((!strobe_style_sel && rd_strobe) [*5] |-> !data_oe)
    else $error("bus driven with read strobe high");
  AST_ENA_EN: assert property ((strobe_style_sel && !rd_strobe) [*5] |-> !data_oe)
    else $error("bus driven with enable low");
  AST_ENA_DIR: assert property ((strobe_style_sel && !wr_strobe) [*5] |-> !data_oe)
    else $error("bus driven during write direction");
  AST_STATUS_LOW: assert property ($rose(data_oe) && !$past(data_cmd_sel, 2) |-> data_out[4:0] == 5'h00)
    else $error("status low bits not zero");
  AST_PWR_SAVE: assert property (mode.power_save == (!mode.disp_on && mode.all_on))
    else $error("power save flag wrong");
  AST_WR_HOLD: assert property (ram_wr_valid && !ram_wr_ready |=> ram_wr_valid && $stable(ram_wr))
    else $error("stalled write lost or changed");
  AST_RST_DEF: assert property ($rose(nrst) |-> mode == 20'h0_0000 && col_addr == 8'h00 && page_addr == 4'h0)
    else $error("state not default after reset");
  AST_SER_IDLE: assert property ((!iface_serial_parallel_sel && !data_in[6]) [*6] |-> $stable(mode))
    else $error("mode changed without shift clock");
endmodule : lcd_host_port_chk

bind lcd_host_port lcd_host_port_chk u_chk (.clk(clk), .nrst(nrst),
  .iface_serial_parallel_sel(iface_serial_parallel_sel), .strobe_style_sel(strobe_style_sel),
  .chip_select_n(chip_select_n), .data_cmd_sel(data_cmd_sel), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ram_wr_valid(ram_wr_valid),
  .ram_wr_ready(ram_wr_ready), .ram_wr(ram_wr), .page_addr(page_addr), .col_addr(col_addr),
  .ram_rd_data(ram_rd_data), .mode(mode), .host_busy(host_busy));

/* tb/lcd_host_model.sv */
// Host processor model: parallel bus in both strobe styles and serial link
`timescale 1ns/1ps
module lcd_host_model (
  input  wire logic       clk,                       // Clock
  input  wire logic [7:0] data_out,                  // Device bus value
  input  wire logic       data_oe,                   // Device drives bus
  output logic            iface_serial_parallel_sel, // Interface
  output logic            strobe_style_sel,          // Style
  output logic            chip_select_n,             // Select
  output logic            data_cmd_sel,              // Data/command
  output logic            rd_strobe,                 // Read/enable
  output logic            wr_strobe,                 // Write/direction
  output logic [7:0]      data_in                    // Resolved bus
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic       drv_en = 1'b0;
  logic       sck = 1'b0;
  logic       sdi = 1'b0;
  logic       cs_block = 1'b0;
  initial begin
    iface_serial_parallel_sel = 1'b1;
    strobe_style_sel = 1'b0;
    chip_select_n = 1'b1;
    data_cmd_sel = 1'b0;
    rd_strobe = 1'b1;
    wr_strobe = 1'b1;
  end
  // Released bus shows the inverse of its last level
  always_comb begin
    if (data_oe)
      data_in = data_out;
    else if (!iface_serial_parallel_sel)
      data_in = {sdi, sck, 6'h3F};
    else if (drv_en)
      data_in = drv;
    else
      data_in = ~last;
  end
  always @(posedge clk)
    if (data_oe || drv_en)
      last <= data_in;
  ////////////////////////////////////////////////////////////
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  task automatic setup(input logic par, input logic ena);
    gap(1);
    chip_select_n = 1'b1;
    iface_serial_parallel_sel = par;
    strobe_style_sel = ena;
    rd_strobe = !ena;
    wr_strobe = 1'b1;
    sck = 1'b0;
  endtask : setup
  task automatic par_wr(input logic dc, input logic [7:0] b);
    gap(1);
    chip_select_n = cs_block;
    data_cmd_sel = dc;
    drv = b;
    drv_en = 1'b1;
    wr_strobe = 1'b0;
    gap(4);
    if (strobe_style_sel) begin
      rd_strobe = 1'b1;
      gap(4);
      rd_strobe = 1'b0;
    end else
      wr_strobe = 1'b1;
    gap(4);
    wr_strobe = 1'b1;
    chip_select_n = 1'b1;
    drv_en = 1'b0;
    gap(4);
  endtask : par_wr
  task automatic par_rd(input logic dc, output logic [7:0] v);
    gap(1);
    chip_select_n = cs_block;
    data_cmd_sel = dc;
    rd_strobe = strobe_style_sel;
    gap(6);
    v = data_in;
    rd_strobe = !strobe_style_sel;
    gap(4);
    chip_select_n = 1'b1;
    gap(4);
  endtask : par_rd
  task automatic ser_wr(input logic dc, input logic [7:0] b, input int n, input logic hold);
    gap(1);
    chip_select_n = cs_block;
    data_cmd_sel = dc;
    for (int i = 7; i > 7 - n; i--) begin
      sdi = b[i];
      sck = 1'b0;
      gap(4);
      sck = 1'b1;
      gap(4);
    end
    sck = 1'b0;
    gap(4);
    if (!hold)
      chip_select_n = 1'b1;
    gap(4);
  endtask : ser_wr
endmodule : lcd_host_model

/* tb/test_lcd_host_port.sv */
// Self-checking bench of the display host port
`timescale 1ns/1ps
module test_lcd_host_port;
  import lcd_pkg::*;
  localparam logic [7:0] SET_SEQ [9] = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'h6A, 8'hB5, 8'h13, 8'h0C, 8'hF8};
  localparam logic [7:0] CLR_SEQ [4] = '{8'hAE, 8'hA0, 8'hA6, 8'h40};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ram_wr_ready = 1'b1;
  logic        iface_serial_parallel_sel, strobe_style_sel, chip_select_n, data_cmd_sel, rd_strobe, wr_strobe;
  logic [7:0]  data_in, data_out, ram_rd_data, col_addr;
  logic        data_oe, ram_wr_valid, host_busy;
  logic [3:0]  page_addr;
  lcd_ram_wr_t ram_wr;
  lcd_mode_t   mode;
  lcd_ram_wr_t taken [$];
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #50 clk = ~clk;
  // RAM stand-in: contents follow the address
  assign ram_rd_data = {page_addr, col_addr[3:0]} ^ 8'h5A;
  lcd_host_port uut (.clk(clk), .nrst(nrst), .iface_serial_parallel_sel(iface_serial_parallel_sel),
    .strobe_style_sel(strobe_style_sel), .chip_select_n(chip_select_n), .data_cmd_sel(data_cmd_sel),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ram_wr_valid(ram_wr_valid), .ram_wr_ready(ram_wr_ready), .ram_wr(ram_wr), .page_addr(page_addr),
    .col_addr(col_addr), .ram_rd_data(ram_rd_data), .mode(mode), .host_busy(host_busy));
  lcd_host_model host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .iface_serial_parallel_sel(iface_serial_parallel_sel), .strobe_style_sel(strobe_style_sel),
    .chip_select_n(chip_select_n), .data_cmd_sel(data_cmd_sel), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .data_in(data_in));
  always @(posedge clk) begin
    if (ram_wr_valid && ram_wr_ready)
      taken.push_back(ram_wr);
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_mode(input lcd_mode_t got, input lcd_mode_t exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_mode
  task automatic cmd(input logic [7:0] b);
    if (iface_serial_parallel_sel)
      host.par_wr(1'b0, b);
    else
      host.ser_wr(1'b0, b, 8, 1'b0);
  endtask : cmd
  ////////////////////////////////////////////////////////////
  task automatic sc_cmds(input logic par, input logic ena, input logic [1:0] bst);
    lcd_mode_t em;
    host.setup(par, ena);
    foreach (SET_SEQ[i]) cmd(SET_SEQ[i]);
    cmd({6'h00, bst});
    em = '{disp_on:1'b1, seg_rev:1'b1, inverse:1'b1, all_on:1'b1, power_save:1'b0, rmw:1'b0,
           booster:bst, start_line:6'h2A};
    cmp_mode(mode, em, "modes set");
    cmp_byte({4'h0, page_addr}, 8'h05, "page");
    cmp_byte(col_addr, 8'h3C, "column");
    foreach (CLR_SEQ[i]) cmd(CLR_SEQ[i]);
    em = '{disp_on:1'b0, seg_rev:1'b0, inverse:1'b0, all_on:1'b1, power_save:1'b1, rmw:1'b0,
           booster:bst, start_line:6'h00};
    cmp_mode(mode, em, "modes cleared, power save");
    cmd(8'hA4);
    em.all_on = 1'b0;
    em.power_save = 1'b0;
    cmp_mode(mode, em, "all points normal");
  endtask : sc_cmds
  task automatic sc_status(input logic ena);
    logic [7:0] v;
    host.setup(1'b1, ena);
    cmd(8'hA1);
    cmd(8'hAE);
    host.par_rd(1'b0, v);
    cmp_byte(v, 8'h60, "status byte");
  endtask : sc_status
  task automatic sc_data();
    logic [7:0] v;
    taken.delete();
    host.setup(1'b1, 1'b0);
    ram_wr_ready = 1'b0;
    cmd(8'hB3);
    cmd(8'h10);
    cmd(8'h08);
    host.par_wr(1'b1, 8'h11);
    host.par_wr(1'b1, 8'h22);
    host.par_wr(1'b1, 8'h33);
    cmp_byte({7'h00, host_busy}, 8'h01, "buffer full");
    cmp_byte(col_addr, 8'h0A, "column after refused write");
    host.par_rd(1'b0, v);
    cmp_byte(v, 8'hE0, "status while full");
    ram_wr_ready = 1'b1;
    host.gap(4);
    cmp_byte(8'(taken.size()), 8'h02, "writes taken");
    cmp_byte(taken[0].data, 8'h11, "first data");
    cmp_byte(taken[0].col, 8'h08, "first column");
    cmp_byte(taken[1].data, 8'h22, "second data");
    cmp_byte({taken[1].page, taken[1].col[3:0]}, 8'h39, "second address");
  endtask : sc_data
  task automatic sc_read();
    logic [7:0] v;
    host.setup(1'b1, 1'b1);
    cmd(8'hB2);
    cmd(8'hE2);
    cmd(8'h04);
    host.par_rd(1'b1, v);
    cmp_byte(v, 8'h5E, "ram read");
    cmp_byte(col_addr, 8'h05, "column after read");
    cmd(8'hE0);
    host.par_rd(1'b1, v);
    cmp_byte(v, 8'h5F, "ram read in rmw");
    cmp_byte(col_addr, 8'h05, "column after rmw read");
    host.par_wr(1'b1, 8'h44);
    cmp_byte(col_addr, 8'h06, "column after rmw write");
    cmd(8'hEE);
    host.par_rd(1'b1, v);
    cmp_byte(col_addr, 8'h07, "column after rmw end");
  endtask : sc_read
  task automatic sc_cs();
    host.cs_block = 1'b1;
    cmd(8'hAF);
    host.setup(1'b0, 1'b0);
    cmd(8'hAF);
    host.cs_block = 1'b0;
    cmp_byte({7'h00, mode.disp_on}, 8'h00, "deselected writes");
    host.ser_wr(1'b0, 8'hFF, 3, 1'b0);
    cmd(8'hAF);
    cmp_byte({7'h00, mode.disp_on}, 8'h01, "partial byte dropped");
  endtask : sc_cs
  task automatic sc_reset();
    host.ser_wr(1'b0, 8'hFF, 5, 1'b1);
    nrst = 1'b0;
    host.gap(2);
    nrst = 1'b1;
    cmp_mode(mode, 20'h0_0000, "modes after reset");
    cmp_byte(col_addr, 8'h00, "column after reset");
    cmp_byte({4'h0, page_addr}, 8'h00, "page after reset");
    host.gap(4);
    cmd(8'hAF);
    cmp_byte({7'h00, mode.disp_on}, 8'h01, "byte after reset");
  endtask : sc_reset
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    host.gap(4);
    sc_cmds(1'b1, 1'b0, 2'h3);
    sc_cmds(1'b1, 1'b1, 2'h1);
    sc_cmds(1'b0, 1'b0, 2'h0);
    sc_status(1'b0);
    sc_status(1'b1);
    sc_data();
    sc_read();
    sc_cs();
    sc_reset();
    close_out();
  end
endmodule : test_lcd_host_port
